// ==== hdl/udc_defs.svh ====
// Constants of the up/down pulse counter: bus offsets, byte fields, resets.
// Assumes inclusion by bare name from the format mapper and the core module; the package does not include it.
`ifndef UDC_DEFS_SVH
`define UDC_DEFS_SVH

// ----------------------------------------------------------------------
// Bus byte offsets
// ----------------------------------------------------------------------
`define UDC_OFS_CTRL 4'h0
`define UDC_OFS_DOUT 4'h4
`define UDC_OFS_DIN 4'h8
`define UDC_OFS_LEN 4'hc

// ----------------------------------------------------------------------
// Control and status byte fields
// ----------------------------------------------------------------------
`define UDC_CB_OUT_FIRST 0
`define UDC_CB_OUT_SECOND 1
`define UDC_CB_PRESET 2
`define UDC_CB_INHIBIT 3
`define UDC_SB_DIR 4
`define UDC_SB_COUNT 5
`define UDC_CB_WNR 6
`define UDC_CB_REG 7

// ----------------------------------------------------------------------
// Internal register indices and feature fields
// ----------------------------------------------------------------------
`define UDC_REG_CNT_LO 6'h00
`define UDC_REG_CNT_HI 6'h01
`define UDC_REG_TYPE 6'h08
`define UDC_REG_FEATURE 6'h20
`define UDC_REG_CMP_FIRST 6'h21
`define UDC_REG_CMP_SECOND 6'h22
`define UDC_FT_GATE_HIGH 2
`define UDC_FT_ALT 3
`define UDC_FT_AUTO 4
`define UDC_TYPE_ID 16'h0a5a
`define UDC_RST_FEATURE 16'h0000

// ----------------------------------------------------------------------
// Exchanged data lengths in bytes
// ----------------------------------------------------------------------
`define UDC_LEN_STD 3'h5
`define UDC_LEN_ALT_SINGLE 3'h4
`define UDC_LEN_ALT_DUAL 3'h6

`endif

// ==== hdl/udc_pkg.sv ====
// Types shared by the up/down pulse counter modules.
// Assumes udc_defs.svh for the numeric constants.
package udc_pkg;

    // Counting modes
    typedef enum logic [1:0] {
        UDC_MODE_UPDOWN,
        UDC_MODE_GATED,
        UDC_MODE_DUAL
    } udc_mode_t;

    // Feature settings steered by software
    typedef struct packed {
        udc_mode_t mode;
        logic gate_high;
        logic alt_fmt;
        logic auto_en;
    } udc_feat_t;

    // Indicator levels
    typedef struct packed {
        logic dir;
        logic count;
        logic out_first;
        logic out_second;
    } udc_led_t;

    // Whole state of the counter core
    typedef struct packed {
        udc_feat_t feat;
        logic [15:0] cmp_first;
        logic [15:0] cmp_second;
        logic [31:0] cnt;
        logic [15:0] cnt_b;
        logic [7:0] ctrl;
        logic [7:0] status;
        logic [31:0] dout;
        logic [31:0] din;
        logic [2:0] len;
        logic auto_first;
        logic auto_second;
        logic out_first;
        logic out_second;
        udc_led_t led;
        logic ack;
        logic [31:0] rdata;
    } udc_state_t;

    // Edge detector state
    typedef struct packed {
        logic prev;
    } udc_edge_state_t;

endpackage

// ==== hdl/udc_edge.sv ====
// Rising edge detector for one synchronous field input.
// Assumes the input is already synchronous to clock_i.
`timescale 1ns/10ps
module udc_edge import udc_pkg::*; (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Level in, pulse out
    input wire logic level_i,
    output logic rise_o
);
    udc_edge_state_t st_reg; // Previous level
    udc_edge_state_t st_next;

    // Previous starts high so a level already high at reset is no edge
    always_comb begin
        st_next = st_reg;
        st_next.prev = level_i;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_reg.prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rise_o = level_i & ~st_reg.prev;
endmodule

// ==== hdl/udc_fmt.sv ====
// Output format mapper: turns the counters into the reported data word.
// Assumes the caller registers the result before it leaves the block.
`timescale 1ns/10ps
`include "udc_defs.svh"
module udc_fmt import udc_pkg::*; (
    // Settings
    input wire udc_feat_t feat_i,
    // Counters
    input wire logic [31:0] cnt_i,
    input wire logic [15:0] cnt_b_i,
    // Mapped data and its byte length
    output logic [31:0] data_o,
    output logic [2:0] len_o
);
    // Pure mapping; no state of its own
    always_comb begin
        data_o = cnt_i;
        len_o = `UDC_LEN_STD;
        if (!feat_i.alt_fmt) begin
            // Standard: four data bytes plus the control/status byte
            if (feat_i.mode == UDC_MODE_DUAL) begin
                data_o = {cnt_b_i, cnt_i[15:0]};
            end else begin
                data_o = cnt_i;
            end
            len_o = `UDC_LEN_STD;
        end else if (feat_i.mode == UDC_MODE_DUAL) begin
            // Alternative dual: 8-bit first counter, 16-bit second counter
            data_o = {8'h00, cnt_b_i, cnt_i[7:0]};
            len_o = `UDC_LEN_ALT_DUAL;
        end else begin
            // Alternative single: signed 24-bit, sign carried upward
            data_o = {{8{cnt_i[23]}}, cnt_i[23:0]};
            len_o = `UDC_LEN_ALT_SINGLE;
        end
    end
endmodule

// ==== hdl/udc_top.sv ====
// Up/down pulse counter core with an Avalon-MM register slave.
// Assumes count_i and dir_gate_i are already synchronous to clock_i and
// that the coupler side reaches the process image through the bus below.
`timescale 1ns/10ps
`include "udc_defs.svh"
module udc_top import udc_pkg::*; (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Field inputs
    input wire logic count_i,
    input wire logic dir_gate_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Field outputs
    output logic digital_output_first_o,
    output logic digital_output_second_o,
    // Indicators
    output udc_led_t led_o
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    udc_state_t st_reg; // All state of the block
    udc_state_t st_next; // Its next value
    logic [1:0] pin_in; // Count and direction/gate levels
    logic [1:0] rise; // Rising edge pulses of the pins
    logic [31:0] fmt_data; // Mapped count data
    logic [2:0] fmt_len; // Mapped byte length
    logic req; // A bus request is present
    logic wr_ctrl; // Control byte write takes effect now
    logic wr_dout; // Output data write takes effect now
    logic preset_evt; // Preset request from the control byte
    logic inhibit; // Counting suppressed
    logic gate_active; // Gate level allows counting
    logic [7:0] wbyte; // Written control byte

    // ------------------------------------------------------------------
    // Feature register coding
    // ------------------------------------------------------------------
    // Unknown mode codes fall back to up/down so no code can stall counting
    function automatic udc_feat_t feat_decode(input logic [15:0] v);
        udc_feat_t f;
        case (v[1:0])
            2'h1: f.mode = UDC_MODE_GATED;
            2'h2: f.mode = UDC_MODE_DUAL;
            default: f.mode = UDC_MODE_UPDOWN;
        endcase
        f.gate_high = v[`UDC_FT_GATE_HIGH];
        f.alt_fmt = v[`UDC_FT_ALT];
        f.auto_en = v[`UDC_FT_AUTO];
        return f;
    endfunction

    // Feature value as software reads it back
    function automatic logic [15:0] feat_encode(input udc_feat_t f);
        logic [15:0] v;
        v = 16'h0000;
        case (f.mode)
            UDC_MODE_GATED: v[1:0] = 2'h1;
            UDC_MODE_DUAL: v[1:0] = 2'h2;
            default: v[1:0] = 2'h0;
        endcase
        v[`UDC_FT_GATE_HIGH] = f.gate_high;
        v[`UDC_FT_ALT] = f.alt_fmt;
        v[`UDC_FT_AUTO] = f.auto_en;
        return v;
    endfunction

    // Internal register read; unimplemented indices read zero
    function automatic logic [15:0] reg_read(input logic [5:0] idx, input udc_state_t s);
        logic [15:0] v;
        v = 16'h0000;
        if (idx == `UDC_REG_CNT_LO) begin
            v = s.cnt[15:0];
        end else if (idx == `UDC_REG_CNT_HI) begin
            v = s.cnt[31:16];
        end else if (idx == `UDC_REG_TYPE) begin
            v = `UDC_TYPE_ID; // Arbitrary identification value
        end else if (idx == `UDC_REG_FEATURE) begin
            v = feat_encode(s.feat);
        end else if (idx == `UDC_REG_CMP_FIRST) begin
            v = s.cmp_first;
        end else if (idx == `UDC_REG_CMP_SECOND) begin
            v = s.cmp_second;
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Input edges and format mapping
    // ------------------------------------------------------------------
    assign pin_in = {dir_gate_i, count_i};

    // One detector per field input
    for (genvar i = 0; i < 2; i++) begin : g_edge
        udc_edge u_edge (
            .clock_i(clock_i),
            .srst_i(srst_i),
            .level_i(pin_in[i]),
            .rise_o(rise[i])
        );
    end

    udc_fmt u_fmt (
        .feat_i(st_reg.feat),
        .cnt_i(st_reg.cnt),
        .cnt_b_i(st_reg.cnt_b),
        .data_o(fmt_data),
        .len_o(fmt_len)
    );

    // ------------------------------------------------------------------
    // Bus decode helpers
    // ------------------------------------------------------------------
    // One wait cycle: the request is seen, then answered from flops
    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~st_reg.ack;
    assign wbyte = avs_writedata_i[7:0];
    assign wr_ctrl = avs_write_i & st_reg.ack & (avs_address_i == `UDC_OFS_CTRL)
        & avs_byteenable_i[0];
    assign wr_dout = avs_write_i & st_reg.ack & (avs_address_i == `UDC_OFS_DOUT);
    // Preset acts on the rising edge of its control bit, in process mode only
    assign preset_evt = wr_ctrl & ~wbyte[`UDC_CB_REG] & wbyte[`UDC_CB_PRESET]
        & ~st_reg.ctrl[`UDC_CB_PRESET];
    assign inhibit = ~st_reg.ctrl[`UDC_CB_REG] & st_reg.ctrl[`UDC_CB_INHIBIT];
    assign gate_active = dir_gate_i ^ st_reg.feat.gate_high;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // Bus handshake: capture read data first, apply writes on release
        if (req && !st_reg.ack) begin
            st_next.ack = 1'b1;
            if (avs_address_i == `UDC_OFS_CTRL) begin
                st_next.rdata = {24'h000000, st_reg.status};
            end else if (avs_address_i == `UDC_OFS_DOUT) begin
                st_next.rdata = st_reg.dout;
            end else if (avs_address_i == `UDC_OFS_DIN) begin
                st_next.rdata = st_reg.din;
            end else if (avs_address_i == `UDC_OFS_LEN) begin
                st_next.rdata = {29'h00000000, st_reg.len};
            end else begin
                st_next.rdata = 32'h00000000;
            end
        end else begin
            st_next.ack = 1'b0;
        end

        // Output data lanes honour byte enables
        if (wr_dout) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable_i[b]) begin
                    st_next.dout[8*b +: 8] = avs_writedata_i[8*b +: 8];
                end
            end
        end

        // Counting; an inhibit from the control byte freezes every mode
        case (st_reg.feat.mode)
            UDC_MODE_UPDOWN: begin
                if (rise[0] && !inhibit) begin
                    if (dir_gate_i) begin
                        st_next.cnt = st_reg.cnt + 32'h00000001;
                    end else begin
                        st_next.cnt = st_reg.cnt - 32'h00000001;
                    end
                end
            end
            UDC_MODE_GATED: begin
                // Inactive gate holds the count
                if (rise[0] && !inhibit && gate_active) begin
                    st_next.cnt = st_reg.cnt + 32'h00000001;
                end
            end
            UDC_MODE_DUAL: begin
                // Two independent wrap-around 16-bit counters
                if (rise[0] && !inhibit) begin
                    st_next.cnt[15:0] = st_reg.cnt[15:0] + 16'h0001;
                end
                if (rise[1] && !inhibit) begin
                    st_next.cnt_b = st_reg.cnt_b + 16'h0001;
                end
            end
            default: begin
                st_next.cnt = st_reg.cnt;
            end
        endcase

        // Preset beats a coincident count edge
        if (preset_evt) begin
            if (st_reg.feat.mode == UDC_MODE_DUAL) begin
                st_next.cnt[15:0] = st_reg.dout[15:0];
                st_next.cnt_b = st_reg.dout[31:16];
            end else begin
                st_next.cnt = st_reg.dout;
            end
        end

        // Automatic outputs: preset re-arms, a compare match set wins
        if (preset_evt || !st_reg.feat.auto_en) begin
            st_next.auto_first = 1'b0;
            st_next.auto_second = 1'b0;
        end
        if (st_reg.feat.auto_en && st_reg.cnt[15:0] == st_reg.cmp_first) begin
            st_next.auto_first = 1'b1;
        end
        if (st_reg.feat.auto_en && st_reg.cnt[15:0] == st_reg.cmp_second) begin
            st_next.auto_second = 1'b1;
        end

        // Outputs keep their last process-mode request during register access
        if (!st_reg.ctrl[`UDC_CB_REG]) begin
            st_next.out_first = st_reg.ctrl[`UDC_CB_OUT_FIRST] | st_reg.auto_first;
            st_next.out_second = st_reg.ctrl[`UDC_CB_OUT_SECOND] | st_reg.auto_second;
        end else begin
            st_next.out_first = st_reg.out_first | st_reg.auto_first;
            st_next.out_second = st_reg.out_second | st_reg.auto_second;
        end

        // Status byte: live flags in process mode, echo in register mode
        if (!st_reg.ctrl[`UDC_CB_REG]) begin
            st_next.status = 8'h00;
            st_next.status[`UDC_CB_OUT_FIRST] = st_reg.out_first;
            st_next.status[`UDC_CB_OUT_SECOND] = st_reg.out_second;
            st_next.status[`UDC_CB_PRESET] = st_reg.ctrl[`UDC_CB_PRESET];
            st_next.status[`UDC_CB_INHIBIT] = st_reg.ctrl[`UDC_CB_INHIBIT];
            st_next.status[`UDC_SB_DIR] = dir_gate_i;
            st_next.status[`UDC_SB_COUNT] = count_i;
        end else begin
            st_next.status = st_reg.ctrl;
        end

        // Control byte write; a register write completes in the same edge
        if (wr_ctrl) begin
            st_next.ctrl = wbyte;
            if (wbyte[`UDC_CB_REG]) begin
                st_next.status = wbyte;
                if (wbyte[`UDC_CB_WNR]) begin
                    if (wbyte[5:0] == `UDC_REG_FEATURE) begin
                        st_next.feat = feat_decode(st_reg.dout[15:0]);
                    end else if (wbyte[5:0] == `UDC_REG_CMP_FIRST) begin
                        st_next.cmp_first = st_reg.dout[15:0];
                    end else if (wbyte[5:0] == `UDC_REG_CMP_SECOND) begin
                        st_next.cmp_second = st_reg.dout[15:0];
                    end
                end
            end
        end

        // Input image: register value in register mode, count data otherwise
        if (st_reg.ctrl[`UDC_CB_REG]) begin
            st_next.din = {16'h0000, reg_read(st_reg.ctrl[5:0], st_reg)};
        end else begin
            st_next.din = fmt_data;
        end
        st_next.len = fmt_len;

        // Indicators follow the pins and the driven outputs
        st_next.led.dir = dir_gate_i;
        st_next.led.count = count_i;
        st_next.led.out_first = st_reg.out_first;
        st_next.led.out_second = st_reg.out_second;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_reg <= '0;
            st_reg.feat <= feat_decode(`UDC_RST_FEATURE);
            st_reg.len <= `UDC_LEN_STD;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avs_readdata_o = st_reg.rdata;
    assign digital_output_first_o = st_reg.out_first;
    assign digital_output_second_o = st_reg.out_second;
    assign led_o = st_reg.led;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_no_edge_no_count;
        @(posedge clock_i) disable iff (srst_i)
        (!rise[0] && !rise[1] && !preset_evt) |=> $stable(st_reg.cnt) && $stable(st_reg.cnt_b);
    endproperty
    a_no_edge_no_count: assert property (p_no_edge_no_count)
        else $error("count changed without a rising edge");

    property p_down_count;
        @(posedge clock_i) disable iff (srst_i)
        (st_reg.feat.mode == UDC_MODE_UPDOWN && rise[0] && !inhibit && !preset_evt
            && !dir_gate_i) |=> st_reg.cnt == $past(st_reg.cnt) - 32'h00000001;
    endproperty
    a_down_count: assert property (p_down_count)
        else $error("low direction did not count down");

    property p_gate_hold;
        @(posedge clock_i) disable iff (srst_i)
        (st_reg.feat.mode == UDC_MODE_GATED && !gate_active && !preset_evt)
            |=> $stable(st_reg.cnt);
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("gated count moved with gate inactive");

    property p_second_counter;
        @(posedge clock_i) disable iff (srst_i)
        (st_reg.feat.mode == UDC_MODE_DUAL && rise[1] && !inhibit && !preset_evt)
            |=> st_reg.cnt_b == $past(st_reg.cnt_b) + 16'h0001;
    endproperty
    a_second_counter: assert property (p_second_counter)
        else $error("second counter missed a gate edge");

    property p_preset;
        @(posedge clock_i) disable iff (srst_i)
        (preset_evt && st_reg.feat.mode != UDC_MODE_DUAL) |=> st_reg.cnt == $past(st_reg.dout);
    endproperty
    a_preset: assert property (p_preset)
        else $error("preset value not loaded");

    property p_auto_out;
        @(posedge clock_i) disable iff (srst_i)
        (st_reg.feat.auto_en && st_reg.cnt[15:0] == st_reg.cmp_first) |=> ##1 st_reg.out_first;
    endproperty
    a_auto_out: assert property (p_auto_out)
        else $error("automatic output not set at compare value");

    property p_std_len;
        @(posedge clock_i) disable iff (srst_i)
        !st_reg.feat.alt_fmt |=> st_reg.len == `UDC_LEN_STD;
    endproperty
    a_std_len: assert property (p_std_len)
        else $error("standard format length is not five");

    property p_led_follow;
        @(posedge clock_i) disable iff (srst_i)
        ##1 (led_o.count == $past(count_i) && led_o.dir == $past(dir_gate_i));
    endproperty
    a_led_follow: assert property (p_led_follow)
        else $error("indicator does not follow its input");

    property p_reg_write_done;
        @(posedge clock_i) disable iff (srst_i)
        (wr_ctrl && wbyte[7:6] == 2'h3) |=> st_reg.status == $past(wbyte);
    endproperty
    a_reg_write_done: assert property (p_reg_write_done)
        else $error("status does not echo register write");
endmodule

// ==== dv/udc_cpl.sv ====
// Coupler-side bus master model for the pulse counter's process image.
// Assumes the slave answers with waitrequest and readdata on clock_i.
`timescale 1ns/10ps
module udc_cpl import udc_pkg::*; (
    // Clock
    input wire logic clock_i,
    // Slave answer
    input wire logic [31:0] rdata_i,
    input wire logic wait_i,
    // Request
    output logic [3:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [31:0] wdata_o,
    output logic [3:0] be_o
);
    // -----------------------------------------------------------------
    // Bus cycle
    // -----------------------------------------------------------------
    initial begin
        {addr_o, rd_o, wr_o, wdata_o, be_o} = '0;
    end
    // Control byte sits at offset zero, lane zero; a request is held
    // until waitrequest is sampled low at a rising edge, or for at most 50 edges, then released there
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge clock_i);
        addr_o <= a;
        wr_o <= w;
        rd_o <= !w;
        wdata_o <= d;
        be_o <= 4'hf;
        do begin
            @(posedge clock_i);
            n++;
        end while (wait_i !== 1'b0 && n < 50);
        // Read data stands at the very edge where waitrequest is low
        q = rdata_i;
        ok = (wait_i === 1'b0);
        rd_o <= 1'b0;
        wr_o <= 1'b0;
    endtask
endmodule

// ==== dv/test_up_down_pulse_counter.sv ====
// Self-checking bench for the pulse counter core.
// Assumes udc_top and the coupler model udc_cpl.
`timescale 1ns/10ps
module test_up_down_pulse_counter import udc_pkg::*;;
    logic clock_i, srst_i, count_i, dir_gate_i, rd, wr, wt, do1, do2;
    logic [3:0] addr, be;
    logic [31:0] wd, rdat;
    udc_led_t led;
    int bad_count = 0;
    int tests_run = 0;
    always #25 clock_i = !clock_i;
    udc_top udc_top_i (.clock_i(clock_i), .srst_i(srst_i), .count_i(count_i),
        .dir_gate_i(dir_gate_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .digital_output_first_o(do1),
        .digital_output_second_o(do2), .led_o(led));
    udc_cpl udc_cpl_i (.clock_i(clock_i), .rdata_i(rdat), .wait_i(wt), .addr_o(addr),
        .rd_o(rd), .wr_o(wr), .wdata_o(wd), .be_o(be));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        logic ok;
        udc_cpl_i.xfer(w, a, d, q, ok);
        if (!ok) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    task automatic wrc(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask
    // Register write, then read back and check the status echo, then back to process mode
    task automatic setreg(input logic [5:0] i, input logic [31:0] v);
        wrc(4'h4, v);
        wrc(4'h0, {24'h0, 2'b11, i});
        rdc(4'h0, {24'h0, 2'b11, i}, "status echo");
        wrc(4'h0, 32'h0);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock_i);
            count_i <= 1'b1;
            @(posedge clock_i);
            count_i <= 1'b0;
        end
        @(posedge clock_i);
    endtask
    initial begin
        {clock_i, count_i, dir_gate_i} = '0;
        srst_i = 1'b1;
        repeat (8) @(posedge clock_i);
        srst_i <= 1'b0;
        rdc(4'hc, 32'h5, "reset length");
        rdc(4'h8, 32'h0, "reset count");
        dir_gate_i <= 1'b1;
        pulse(3);
        dir_gate_i <= 1'b0;
        pulse(5);
        rdc(4'h8, 32'hffff_fffe, "up down count");
        wrc(4'h4, 32'h100);
        wrc(4'h0, 32'h4);
        rdc(4'h8, 32'h100, "preset");
        wrc(4'h0, 32'h8);
        pulse(2);
        rdc(4'h8, 32'h100, "inhibit");
        wrc(4'h0, 32'h3);
        // Output levels reach the status byte two edges after the write
        @(posedge clock_i);
        rdc(4'h0, 32'h3, "status outputs");
        chk("outputs", 32'h3, {30'h0, do1, do2});
        chk("indicators", 32'h3, {28'h0, led});
        setreg(6'h20, 32'h1);
        pulse(2);
        rdc(4'h8, 32'h100, "gate closed");
        dir_gate_i <= 1'b1;
        pulse(2);
        rdc(4'h8, 32'h102, "gate open");
        setreg(6'h20, 32'ha);
        rdc(4'hc, 32'h6, "alt dual length");
        wrc(4'h4, 32'h0002_0005);
        wrc(4'h0, 32'h4);
        wrc(4'h0, 32'h0);
        dir_gate_i <= 1'b0;
        pulse(1);
        dir_gate_i <= 1'b1;
        pulse(0);
        rdc(4'h8, 32'h0000_0306, "alt dual data");
        // Automatic first output: compare at 8, count up from 6
        setreg(6'h21, 32'h8);
        setreg(6'h20, 32'h10);
        pulse(2);
        rdc(4'h8, 32'h8, "auto count");
        chk("auto outputs", 32'h2, {30'h0, do1, do2});
        // Alternative single format carries the sign of bit 23 upward
        setreg(6'h20, 32'h8);
        wrc(4'h4, 32'h00ff_fff0);
        wrc(4'h0, 32'h4);
        rdc(4'h8, 32'hffff_fff0, "alt single data");
        rdc(4'hc, 32'h4, "alt single length");
        // Gated with high gate level suppressing counts
        setreg(6'h20, 32'h5);
        pulse(1);
        rdc(4'h8, 32'h00ff_fff0, "gate high hold");
        tally_and_finish();
    end
endmodule
